/* File: see_core.sv */
// serial eeprom command port: write-data fifo and top level
//
// Operation
// - first byte of each selection is the opcode; it steers decoding
// - serial input sampled on rising clock while selected and not paused
// - opcode, address and data shift most significant bit first
// - first bit is taken on first rising clock after select falls
// - while paused every input except select is ignored
// - after pause, the transaction resumes at the same bit
// - 03h reads, 02h writes, starting at the following address
// - 06h sets the write latch, 04h clears it
// - 05h shifts status out, 01h loads writable status bits
// - 42h erases a page, D8h a sector, C7h the whole array
// - B9h enters deep sleep; ABh wakes and shifts out the signature
// - read is opcode, 16-bit address, then addressed byte shifted out
// - read pointer advances after each byte shifted out
// - read pointer wraps from FFFFh to 0000h
// - read ends only when select rises; output released, context dropped
// - byte or page write and page erase finish within 5 ms
// - sector and chip erase finish within 10 ms
// - standby and deep sleep reached within 100 us of select rising
// - 128-byte pages, 16 KiB sectors for erase and protection
// - 65536-byte array using all 16 address bits
// - status bit 0 shows busy, bit 1 the write latch, both read-only
// - up to 128 write bytes; overflow wraps within the page
// - write starts only if select rises right after a whole byte
// - protect bits guard none, from C000h, from 8000h, or everything
`timescale 1ns/10ps
`include "see_params.svh"

// ****************************************************************
// write-data fifo
// ****************************************************************
module see_fifo #(
  parameter int W = 15,
  parameter int D = 16
) (
  input  wire logic         clk,
  input  wire logic         nrst,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(D);
  logic [W-1:0] buf_mem [D];
  logic [AW:0]  wp_reg;
  logic [AW:0]  rp_reg;

  assign in_ready  = (wp_reg - rp_reg) != (AW+1)'(D);
  assign out_valid = wp_reg != rp_reg;
  assign out_data  = buf_mem[rp_reg[AW-1:0]];

  always_ff @(posedge clk) begin
    if (!nrst) begin
      wp_reg <= '0;
    end else if (in_valid && in_ready) begin
      wp_reg <= wp_reg + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (in_valid && in_ready) begin
      buf_mem[wp_reg[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      rp_reg <= '0;
    end else if (out_valid && out_ready) begin
      rp_reg <= rp_reg + 1'b1;
    end
  end
endmodule : see_fifo

// ****************************************************************
// top level
// ****************************************************************
module see_top #(
  parameter int unsigned WRITE_CYC = `SEE_WRITE_CYC,
  parameter int unsigned ERASE_CYC = `SEE_ERASE_CYC,
  parameter logic [7:0]  SIG_BYTE  = 8'h5A  // arbitrary signature value
) (
  input  wire logic clk,
  input  wire logic nrst,
  input  wire logic cs_n,
  input  wire logic sck,
  input  wire logic si,
  input  wire logic hold_n,
  input  wire logic wp_n,
  output logic      so,
  output logic      so_oe,
  output logic      busy,
  output logic      write_latch,
  output logic      deep_sleep
);
  import see_pkg::*;

  logic [4:0]   s1_reg;
  logic [4:0]   s2_reg;
  logic         sck_d_reg;
  logic         cs_d_reg;
  logic         cs_s2;
  logic         sck_s2;
  logic         si_s2;
  logic         hold_s2;
  logic         wp_s2;
  logic         active;
  logic         rise;
  logic         fall;
  logic         cs_fall;
  logic         cs_rise;
  see_state_t   st_reg;
  logic [2:0]   bcnt_reg;
  logic [3:0]   acnt_reg;
  logic [7:0]   shift_reg;
  logic [7:0]   opc_reg;
  logic [7:0]   in_byte;
  logic [15:0]  addr_reg;
  logic         got_reg;
  logic         bad_reg;
  logic [7:0]   sr_in_reg;
  logic [2:0]   obit_reg;
  logic [7:0]   out_byte_reg;
  logic         oe_arm_reg;
  logic         so_reg;
  logic         so_oe_reg;
  logic         addr_inc;
  logic         out_state;
  logic [7:0]   src_byte;
  logic [7:0]   status_byte;
  logic         wel_reg;
  logic         wpen_reg;
  logic [1:0]   bp_reg;
  logic         sleep_reg;
  logic         busy_reg;
  logic [7:0]   mem [65536];
  logic [7:0]   mem_q_reg;
  logic [7:0]   pbuf [128];
  logic [127:0] mask_reg;
  see_item_t    push_item;
  see_item_t    pop_item;
  logic         push_valid;
  logic         push_ready;
  logic         pop_valid;
  logic         pop_ready;
  see_job_t     job_reg;
  logic [7:0]   kind_reg;
  logic [15:0]  base_reg;
  logic [16:0]  span_reg;
  logic [16:0]  it_reg;
  logic [31:0]  t_reg;
  logic         start_job;
  logic         job_done;
  logic [31:0]  limit;
  logic         mem_we;
  logic [15:0]  mem_wa;
  logic [7:0]   mem_wd;

  function automatic logic prot_f(input logic [15:0] a, input logic [1:0] bp);
    if (bp == `SEE_BP_NONE) return 1'b0;
    else if (bp == `SEE_BP_QUARTER) return a[15:14] == `SEE_TOP_QUARTER;
    else if (bp == `SEE_BP_HALF) return a[15];
    else return 1'b1;
  endfunction : prot_f

  // ****************************************************************
  // pin synchronisers and edge finding
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (!nrst) begin
      s1_reg    <= `SEE_PIN_IDLE;
      s2_reg    <= `SEE_PIN_IDLE;
      sck_d_reg <= 1'b0;
      cs_d_reg  <= 1'b1;
    end else begin
      s1_reg    <= {wp_n, hold_n, si, sck, cs_n};
      s2_reg    <= s1_reg;
      sck_d_reg <= s2_reg[1];
      cs_d_reg  <= s2_reg[0];
    end
  end

  assign cs_s2   = s2_reg[0];
  assign sck_s2  = s2_reg[1];
  assign si_s2   = s2_reg[2];
  assign hold_s2 = s2_reg[3];
  assign wp_s2   = s2_reg[4];
  assign active  = !cs_s2 && hold_s2;
  assign rise    = active && sck_s2 && !sck_d_reg;
  assign fall    = active && !sck_s2 && sck_d_reg;
  assign cs_fall = !cs_s2 && cs_d_reg;
  assign cs_rise = cs_s2 && !cs_d_reg;
  assign in_byte = {shift_reg[6:0], si_s2};

  // ****************************************************************
  // command sequencer
  // ****************************************************************
  assign out_state = (st_reg == ST_RDATA) || (st_reg == ST_SRD);
  assign addr_inc  = fall && (st_reg == ST_RDATA) && obit_reg == `SEE_LAST_BIT;
  assign push_valid = rise && (st_reg == ST_WDATA) && bcnt_reg == `SEE_LAST_BIT;
  assign push_item  = '{off: addr_reg[6:0], data: in_byte};

  always_ff @(posedge clk) begin
    if (!nrst) begin
      st_reg    <= ST_IDLE;
      bcnt_reg  <= '0;
      acnt_reg  <= '0;
      shift_reg <= '0;
      opc_reg   <= '0;
      addr_reg  <= '0;
      got_reg   <= 1'b0;
      bad_reg   <= 1'b0;
      sr_in_reg <= '0;
    end else if (cs_s2) begin
      st_reg <= ST_IDLE;
    end else if (cs_fall) begin
      st_reg   <= ST_OPC;
      bcnt_reg <= '0;
      acnt_reg <= '0;
      got_reg  <= 1'b0;
      bad_reg  <= 1'b0;
    end else if (rise) begin
      // paused cycles never reach here, so the bit count simply waits
      shift_reg <= in_byte;
      bcnt_reg  <= bcnt_reg + 1'b1;
      case (st_reg)
        ST_OPC: begin
          if (bcnt_reg == `SEE_LAST_BIT) begin
            opc_reg <= in_byte;
            if (busy_reg && in_byte != `SEE_OP_STATUS_RD) st_reg <= ST_IGN;
            else if (sleep_reg && in_byte != `SEE_OP_WAKE_SIG) st_reg <= ST_IGN;
            else begin
              case (in_byte)
                `SEE_OP_READ, `SEE_OP_WRITE, `SEE_OP_PAGE_ERASE,
                `SEE_OP_SECT_ERASE, `SEE_OP_WAKE_SIG: st_reg <= ST_ADDR;
                `SEE_OP_STATUS_RD: st_reg <= ST_SRD;
                `SEE_OP_STATUS_WR: st_reg <= ST_SWR;
                `SEE_OP_SET_LATCH, `SEE_OP_CLR_LATCH,
                `SEE_OP_CHIP_ERASE, `SEE_OP_DEEP_SLEEP: st_reg <= ST_CMD;
                default: st_reg <= ST_IGN;
              endcase
            end
          end
        end
        ST_ADDR: begin
          addr_reg <= {addr_reg[14:0], si_s2};
          acnt_reg <= acnt_reg + 1'b1;
          if (acnt_reg == `SEE_LAST_ADDR_BIT) begin
            if (opc_reg == `SEE_OP_READ || opc_reg == `SEE_OP_WAKE_SIG) st_reg <= ST_RDATA;
            else if (opc_reg == `SEE_OP_WRITE) st_reg <= ST_WDATA;
            else st_reg <= ST_CMD;
          end
        end
        ST_WDATA: begin
          if (bcnt_reg == `SEE_LAST_BIT) begin
            got_reg  <= 1'b1;
            bad_reg  <= bad_reg || !push_ready;       // full fifo spoils the write
            addr_reg <= {addr_reg[15:7], addr_reg[6:0] + 7'h01};
          end
        end
        ST_SWR: begin
          if (bcnt_reg == `SEE_LAST_BIT) begin
            sr_in_reg <= in_byte;
            st_reg    <= ST_SWRD;
          end
        end
        ST_SWRD, ST_CMD: st_reg <= ST_IGN;            // extra clocks cancel
        default: st_reg <= st_reg;
      endcase
    end else if (addr_inc) begin
      addr_reg <= addr_reg + 16'h0001;
    end
  end

  // ****************************************************************
  // serial output
  // ****************************************************************
  assign status_byte = {wpen_reg, 3'h0, bp_reg, wel_reg, busy_reg};
  assign src_byte = (st_reg == ST_SRD) ? status_byte :
                    (opc_reg == `SEE_OP_WAKE_SIG) ? SIG_BYTE : mem_q_reg;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      obit_reg     <= '0;
      out_byte_reg <= '0;
      oe_arm_reg   <= 1'b0;
      so_reg       <= 1'b0;
      so_oe_reg    <= 1'b0;
    end else begin
      so_oe_reg <= active && out_state && (oe_arm_reg || fall);
      if (cs_s2 || cs_fall) begin
        obit_reg   <= '0;
        oe_arm_reg <= 1'b0;
      end else if (fall && out_state) begin
        oe_arm_reg <= 1'b1;
        obit_reg   <= obit_reg + 1'b1;
        if (obit_reg == 3'h0) begin
          out_byte_reg <= src_byte;
          so_reg       <= src_byte[7];
        end else begin
          so_reg <= out_byte_reg[3'h7 - obit_reg];
        end
      end
    end
  end

  assign so    = so_reg;
  assign so_oe = so_oe_reg;

  // ****************************************************************
  // write latch, status bits, deep sleep
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (!nrst) begin
      wel_reg   <= 1'b0;
      wpen_reg  <= 1'b0;
      bp_reg    <= `SEE_BP_NONE;
      sleep_reg <= 1'b0;
    end else begin
      if (job_done) wel_reg <= 1'b0;
      if (cs_rise) begin
        if (st_reg == ST_CMD && opc_reg == `SEE_OP_SET_LATCH) wel_reg <= 1'b1;
        if (st_reg == ST_CMD && opc_reg == `SEE_OP_CLR_LATCH) wel_reg <= 1'b0;
        if (st_reg == ST_CMD && opc_reg == `SEE_OP_DEEP_SLEEP) sleep_reg <= 1'b1;
        if (opc_reg == `SEE_OP_WAKE_SIG && st_reg != ST_IGN && st_reg != ST_OPC)
          sleep_reg <= 1'b0;
        if (st_reg == ST_SWRD && wel_reg && !(wpen_reg && !wp_s2)) begin
          wpen_reg <= sr_in_reg[`SEE_SR_WP_EN];
          bp_reg   <= sr_in_reg[`SEE_SR_BP_HI:`SEE_SR_BP_LO];
          wel_reg  <= 1'b0;
        end
      end
    end
  end

  assign write_latch = wel_reg;
  assign deep_sleep  = sleep_reg;

  // ****************************************************************
  // self-timed engine
  // ****************************************************************
  always_comb begin
    start_job = 1'b0;
    if (cs_rise && wel_reg && job_reg == J_IDLE) begin
      if (st_reg == ST_WDATA)
        start_job = got_reg && bcnt_reg == 3'h0 && !bad_reg && !prot_f(addr_reg, bp_reg);
      else if (st_reg == ST_CMD && opc_reg == `SEE_OP_CHIP_ERASE)
        start_job = bp_reg == `SEE_BP_NONE;
      else if (st_reg == ST_CMD)
        start_job = (opc_reg == `SEE_OP_PAGE_ERASE || opc_reg == `SEE_OP_SECT_ERASE)
                    && !prot_f(addr_reg, bp_reg);
    end
  end

  assign limit    = (kind_reg == `SEE_OP_WRITE || kind_reg == `SEE_OP_PAGE_ERASE) ?
                    WRITE_CYC : ERASE_CYC;
  assign job_done = job_reg == J_RUN && it_reg >= span_reg && t_reg >= limit - 32'd1;
  assign pop_ready = job_reg != J_RUN;                // page buffer is busy while copying

  always_ff @(posedge clk) begin
    if (!nrst) begin
      job_reg  <= J_IDLE;
      kind_reg <= '0;
      base_reg <= '0;
      span_reg <= '0;
      it_reg   <= '0;
      t_reg    <= '0;
      busy_reg <= 1'b0;
    end else begin
      busy_reg <= start_job || (job_reg != J_IDLE && !job_done);
      case (job_reg)
        J_IDLE: begin
          if (start_job) begin
            job_reg  <= J_DRAIN;
            kind_reg <= opc_reg;
            if (opc_reg == `SEE_OP_CHIP_ERASE) begin
              base_reg <= 16'h0000;
              span_reg <= `SEE_CHIP_SPAN;
            end else if (opc_reg == `SEE_OP_SECT_ERASE) begin
              base_reg <= {addr_reg[15:14], 14'h0000};
              span_reg <= `SEE_SECT_SPAN;
            end else begin
              base_reg <= {addr_reg[15:7], 7'h00};
              span_reg <= `SEE_PAGE_SPAN;
            end
          end
        end
        J_DRAIN: begin
          it_reg <= '0;
          t_reg  <= '0;
          if (!pop_valid) job_reg <= J_RUN;
        end
        J_RUN: begin
          if (it_reg < span_reg) it_reg <= it_reg + 17'h00001;
          t_reg <= t_reg + 32'd1;
          if (job_done) job_reg <= J_IDLE;
        end
        default: job_reg <= J_IDLE;
      endcase
    end
  end

  assign busy = busy_reg;

  // ****************************************************************
  // page buffer, array
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (!nrst) begin
      mask_reg <= '0;
    end else if (job_done || (cs_fall && job_reg == J_IDLE)) begin
      mask_reg <= '0;
    end else if (pop_valid && pop_ready) begin
      mask_reg[pop_item.off] <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (pop_valid && pop_ready) pbuf[pop_item.off] <= pop_item.data;
  end

  assign mem_wa = base_reg + it_reg[15:0];
  assign mem_we = job_reg == J_RUN && it_reg < span_reg &&
                  (kind_reg != `SEE_OP_WRITE || mask_reg[it_reg[6:0]]);
  assign mem_wd = (kind_reg == `SEE_OP_WRITE) ? pbuf[it_reg[6:0]] : `SEE_ERASED;

  always_ff @(posedge clk) begin
    if (mem_we) mem[mem_wa] <= mem_wd;
    mem_q_reg <= mem[addr_reg];
  end

  see_fifo #(.W($bits(see_item_t)), .D(16)) u_fifo (
    .clk       (clk),
    .nrst      (nrst),
    .in_valid  (push_valid),
    .in_ready  (push_ready),
    .in_data   (push_item),
    .out_valid (pop_valid),
    .out_ready (pop_ready),
    .out_data  (pop_item)
  );

  // ****************************************************************
  // checks
  // ****************************************************************
  first_bit_a: assert property (@(posedge clk) disable iff (!nrst)
    cs_fall |=> st_reg == ST_OPC && bcnt_reg == 3'h0) else $error("select fall not restarting");
  sample_a: assert property (@(posedge clk) disable iff (!nrst)
    rise |=> shift_reg[0] == $past(si_s2)) else $error("input bit not sampled");
  hold_freeze_a: assert property (@(posedge clk) disable iff (!nrst)
    (!hold_s2 && !cs_s2 && !cs_fall) |=> $stable(bcnt_reg) && $stable(shift_reg))
    else $error("state moved while paused");
  opc_cap_a: assert property (@(posedge clk) disable iff (!nrst)
    (rise && st_reg == ST_OPC && bcnt_reg == 3'h7) |=> opc_reg == $past(in_byte))
    else $error("opcode not captured");
  ptr_step_a: assert property (@(posedge clk) disable iff (!nrst)
    addr_inc |=> addr_reg == $past(addr_reg) + 16'h0001) else $error("pointer not advanced");
  ptr_wrap_a: assert property (@(posedge clk) disable iff (!nrst)
    (addr_inc && addr_reg == 16'hFFFF) |=> addr_reg == 16'h0000) else $error("no wrap");
  read_end_a: assert property (@(posedge clk) disable iff (!nrst)
    cs_rise |=> st_reg == ST_IDLE && !so_oe_reg) else $error("read not ended");
  oe_pause_a: assert property (@(posedge clk) disable iff (!nrst)
    (!hold_s2 || cs_s2) |=> !so_oe_reg) else $error("output driven while idle");
  latch_set_a: assert property (@(posedge clk) disable iff (!nrst)
    (cs_rise && st_reg == ST_CMD && opc_reg == `SEE_OP_SET_LATCH && !job_done) |=> wel_reg)
    else $error("latch not set");
  page_wrap_a: assert property (@(posedge clk) disable iff (!nrst)
    push_valid |=> addr_reg[15:7] == $past(addr_reg[15:7])) else $error("left page");
  ignore_a: assert property (@(posedge clk) disable iff (!nrst)
    (st_reg == ST_IGN && !cs_s2) |=> st_reg == ST_IGN) else $error("ignored opcode acted");
  write_time_a: assert property (@(posedge clk) disable iff (!nrst)
    (job_reg == J_RUN && (kind_reg == `SEE_OP_WRITE || kind_reg == `SEE_OP_PAGE_ERASE))
    |-> t_reg < WRITE_CYC) else $error("write late");
  erase_time_a: assert property (@(posedge clk) disable iff (!nrst)
    (job_reg == J_RUN && (kind_reg == `SEE_OP_SECT_ERASE || kind_reg == `SEE_OP_CHIP_ERASE))
    |-> t_reg < ERASE_CYC) else $error("erase late");
endmodule : see_top

/* File: see_host.sv */
// spi host model for the eeprom command port
`timescale 1ns/10ps
module see_host (
  input  wire logic clk,
  input  wire logic so,
  output logic      cs_n,
  output logic      sck,
  output logic      si,
  output logic      hold_n
);
  // ****************************************
  // mode 0 host, 8 clk per bit
  // ****************************************
  int cut = 0;  // lowest bit sent; above 0 cuts a byte short
  initial begin
    cs_n   = 1'b1;
    sck    = 1'b0;
    si     = 1'b0;
    hold_n = 1'b1;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick
  task automatic sel();
    tick(1);
    cs_n <= 1'b0;
    tick(4);
  endtask : sel
  task automatic desel();
    tick(4);
    cs_n <= 1'b1;
    si   <= ~si;  // no stale level once released
    tick(6);
  endtask : desel
  // bit hp is preceded by a pause with junk clocks on the shared line
  task automatic xfer(input logic [7:0] d, input int hp, output logic [7:0] q);
    for (int i = 7; i >= cut; i--) begin
      if (i == hp) begin
        tick(4);  // last falling edge must land before the pause
        hold_n <= 1'b0;
        repeat (3) begin
          tick(4);
          sck <= 1'b1;
          si  <= ~si;
          tick(4);
          sck <= 1'b0;
        end
        tick(2);
        hold_n <= 1'b1;
        tick(4);
      end
      si <= d[i];
      tick(5);
      q[i] = so;  // long low phase lets the output settle
      sck <= 1'b1;
      tick(3);
      sck <= 1'b0;
    end
  endtask : xfer
endmodule : see_host

/* File: see_params.svh */
// constants of the serial eeprom command port: opcodes, status layout, timing
`ifndef SEE_PARAMS_SVH
`define SEE_PARAMS_SVH

// ****************************************************************
// opcodes
// ****************************************************************
`define SEE_OP_READ        8'h03
`define SEE_OP_WRITE       8'h02
`define SEE_OP_SET_LATCH   8'h06
`define SEE_OP_CLR_LATCH   8'h04
`define SEE_OP_STATUS_RD   8'h05
`define SEE_OP_STATUS_WR   8'h01
`define SEE_OP_PAGE_ERASE  8'h42
`define SEE_OP_SECT_ERASE  8'hD8
`define SEE_OP_CHIP_ERASE  8'hC7
`define SEE_OP_WAKE_SIG    8'hAB
`define SEE_OP_DEEP_SLEEP  8'hB9

// ****************************************************************
// status bits and array geometry
// ****************************************************************
`define SEE_SR_BUSY        0
`define SEE_SR_LATCH       1
`define SEE_SR_BP_LO       2
`define SEE_SR_BP_HI       3
`define SEE_SR_WP_EN       7
`define SEE_ERASED         8'hFF
`define SEE_LAST_BIT       3'h7
`define SEE_LAST_ADDR_BIT  4'hF
`define SEE_PAGE_SPAN      17'h00080
`define SEE_SECT_SPAN      17'h04000
`define SEE_CHIP_SPAN      17'h10000
`define SEE_BP_NONE        2'h0
`define SEE_BP_QUARTER     2'h1
`define SEE_BP_HALF        2'h2
`define SEE_TOP_QUARTER    2'h3
// pin idle levels {wp_n, hold_n, si, sck, cs_n}; sck idles low so reset makes no false edge
`define SEE_PIN_IDLE       5'h19

// ****************************************************************
// timing
// ****************************************************************
`define SEE_CLK_MHZ        20
`define SEE_T_WRITE_MS     5
`define SEE_T_ERASE_MS     10
`define SEE_WRITE_CYC      (`SEE_T_WRITE_MS * 1000 * `SEE_CLK_MHZ)
`define SEE_ERASE_CYC      (`SEE_T_ERASE_MS * 1000 * `SEE_CLK_MHZ)

`endif

/* File: see_pkg.sv */
// types shared by the serial eeprom command port
package see_pkg;

  typedef enum logic [3:0] {
    ST_IDLE, ST_OPC, ST_ADDR, ST_RDATA, ST_WDATA, ST_SRD, ST_SWR, ST_SWRD, ST_CMD, ST_IGN
  } see_state_t;

  typedef enum logic [1:0] {J_IDLE, J_DRAIN, J_RUN} see_job_t;

  typedef struct packed {
    logic [6:0] off;
    logic [7:0] data;
  } see_item_t;

endpackage : see_pkg

/* File: test_spi_serial_eeprom_command_port.sv */
// self-checking bench for the eeprom command port
`timescale 1ns/10ps
module test_spi_serial_eeprom_command_port;
  // ****************************************
  // harness
  // ****************************************
  localparam int unsigned WCYC = 200;    // short timed cycles keep the run brief
  localparam int unsigned ECYC = 16400;
  localparam logic [7:0]  SIG  = 8'hC3;  // arbitrary signature value
  logic       clk  = 1'b0;
  logic       nrst = 1'b0;
  logic       wp_n = 1'b1;
  logic       cs_n, sck, si, hold_n, so, so_oe, busy, write_latch, deep_sleep;
  logic       so_pin;
  logic [7:0] q;
  logic [7:0] mem [int];
  int         err_total = 0;
  int         tests_run = 0;
  int         seed      = 2;
  int         cyc       = 0;
  always #25 clk = ~clk;
  see_top #(.WRITE_CYC(WCYC), .ERASE_CYC(ECYC), .SIG_BYTE(SIG)) dut_u (
    .clk(clk), .nrst(nrst), .cs_n(cs_n), .sck(sck), .si(si), .hold_n(hold_n), .wp_n(wp_n),
    .so(so), .so_oe(so_oe), .busy(busy), .write_latch(write_latch), .deep_sleep(deep_sleep));
  assign so_pin = so_oe ? so : ~so;  // released line shows the opposite level
  see_host host_u (.clk(clk), .so(so_pin), .cs_n(cs_n), .sck(sck), .si(si), .hold_n(hold_n));
  task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic end_of_test();
    if (err_total == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : end_of_test
  task automatic cmd(input logic [7:0] op);
    host_u.sel();
    host_u.xfer(op, 8, q);
    host_u.desel();
  endtask : cmd
  task automatic opaddr(input logic [7:0] op, input logic [15:0] a);
    host_u.sel();
    host_u.xfer(op, 8, q);
    host_u.xfer(a[15:8], 8, q);
    host_u.xfer(a[7:0], 8, q);
  endtask : opaddr
  task automatic fin(input int lim);
    for (int n = 0; n < lim && busy !== 1'b0; n++)
      @(posedge clk);
    check("busy_end", {7'h00, busy}, 8'h00);
    check("latch_end", {7'h00, write_latch}, 8'h00);
  endtask : fin
  task automatic wr(input logic [15:0] a, input int n, input logic ok);
    logic [7:0] d;
    cmd(8'h06);
    opaddr(8'h02, a);
    for (int i = 0; i < n; i++) begin
      d = 8'($random(seed));
      if (ok)
        mem[int'({a[15:7], 7'(a[6:0] + i)})] = d;
      host_u.xfer(d, (i == 1) ? 2 : 8, q);
    end
    host_u.desel();
    check("busy", {7'h00, busy}, {7'h00, ok});
  endtask : wr
  task automatic rd(input logic [15:0] a, input int n, input int hp);
    opaddr(8'h03, a);
    for (int i = 0; i < n; i++) begin
      host_u.xfer(8'h00, hp, q);
      check("read", q, mem[int'(16'(a + i))]);
    end
    host_u.desel();
    check("so_oe", {7'h00, so_oe}, 8'h00);
  endtask : rd
  task automatic st(input logic [7:0] exp);
    host_u.sel();
    host_u.xfer(8'h05, 8, q);
    host_u.xfer(8'h00, 8, q);
    host_u.desel();
    check("status", q, exp);
  endtask : st
  task automatic sw(input logic [7:0] v);
    cmd(8'h06);
    host_u.sel();
    host_u.xfer(8'h01, 8, q);
    host_u.xfer(v, 8, q);
    host_u.desel();
  endtask : sw
  task automatic erase(input logic [7:0] op, input logic [15:0] a, input int sp, input int lim);
    cmd(8'h06);
    opaddr(op, a);
    host_u.desel();
    check("erase_busy", {7'h00, busy}, 8'h01);
    for (int i = 0; i < sp; i++)
      mem[int'(a) / sp * sp + i] = 8'hFF;
    fin(lim);
  endtask : erase
  always @(posedge clk) begin
    cyc++;
    if (cyc == 60000) begin
      err_total++;
      end_of_test();
    end
  end
  initial begin
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    check("reset", {5'h00, busy, write_latch, deep_sleep}, 8'h00);
    cmd(8'h06);
    check("set", {7'h00, write_latch}, 8'h01);
    cmd(8'h04);
    check("clr", {7'h00, write_latch}, 8'h00);
    wr(16'hFFFF, 2, 1'b1);
    st(8'h03);
    fin(WCYC + 50);
    wr(16'h007F, 3, 1'b1);
    fin(WCYC + 50);
    rd(16'hFFFF, 3, 8);
    rd(16'hFF80, 1, 3);
    sw(8'h04);
    st(8'h04);
    wr(16'hC000, 1, 1'b0);
    cmd(8'h06);
    cmd(8'hC7);
    check("chip_refused", {7'h00, busy}, 8'h00);
    sw(8'h00);
    st(8'h00);
    sw(8'h80);
    wp_n <= 1'b0;
    sw(8'h0C);
    st(8'h82);
    wp_n <= 1'b1;
    sw(8'h00);
    erase(8'h42, 16'h0000, 128, WCYC + 50);
    rd(16'h0000, 2, 8);
    erase(8'hD8, 16'hFFFF, 16384, ECYC + 50);
    rd(16'hFFFF, 2, 8);
    cmd(8'h06);
    opaddr(8'h02, 16'h0001);
    host_u.xfer(8'h12, 8, q);
    host_u.cut = 5;
    host_u.xfer(8'h34, 8, q);
    host_u.cut = 0;
    host_u.desel();
    check("cut_write", {7'h00, busy}, 8'h00);
    rd(16'h0001, 1, 8);
    host_u.sel();
    host_u.xfer(8'hFF, 8, q);
    host_u.xfer(8'h04, 8, q);
    host_u.desel();
    check("unknown_op", {7'h00, write_latch}, 8'h01);
    cmd(8'h04);
    cmd(8'hB9);
    check("sleep", {7'h00, deep_sleep}, 8'h01);
    cmd(8'h06);
    check("sleep_refuse", {7'h00, write_latch}, 8'h00);
    opaddr(8'hAB, 16'h0000);
    host_u.xfer(8'h00, 8, q);
    host_u.desel();
    check("signature", q, SIG);
    check("wake", {7'h00, deep_sleep}, 8'h00);
    end_of_test();
  end
endmodule : test_spi_serial_eeprom_command_port
